// file: led_pin.sv
// One dual-use indicator/strap pin
`timescale 1ns/10ps
module led_pin (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       in_reset,
  input  wire logic       pin_in,
  input  wire logic [1:0] select,
  input  wire logic [2:0] status,
  output logic            strap,
  output logic            led_out,
  output logic            led_oe_n
);

  typedef struct packed {
    logic strap;
    logic led_out;
    logic led_oe_n;
  } led_state_t;

  led_state_t state;
  led_state_t next_state;

  always_comb begin
    next_state = state;
    if (in_reset) begin
      // Released so the strap level can be read
      next_state.led_oe_n = 1'b1;
      next_state.strap = pin_in;
      next_state.led_out = 1'b0;
    end else begin
      next_state.led_oe_n = 1'b0;
      case (select)
        2'h0: next_state.led_out = status[0];
        2'h1: next_state.led_out = status[1];
        2'h2: next_state.led_out = status[2];
        default: next_state.led_out = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= '{strap: 1'b0, led_out: 1'b0, led_oe_n: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign strap = state.strap;
  assign led_out = state.led_out;
  assign led_oe_n = state.led_oe_n;

endmodule

// file: mac_model.sv
// MAC-side view of the receive data wire
`timescale 1ns/10ps
module mac_model (
  input  wire logic                    clk_sys,
  input  wire pin_mode_pkg::mii_pins_t mii_pins,
  output logic                         rx_wire
);
  logic last;
  // A floating wire must not echo its last driven value
  always_ff @(posedge clk_sys) last <= rx_wire;
  always_comb begin
    if (!mii_pins.rx_data.oe_n) rx_wire = mii_pins.rx_data.level;
    else if (mii_pins.rx_data.weak_pull_down) rx_wire = 1'h0;
    else rx_wire = ~last;
  end
endmodule

// file: phy_pin_mode_control.sv
// MII pin mode control, indicator/strap pins and test port edges
`timescale 1ns/10ps
module phy_pin_mode_control (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       phy_reset_n,
  input  wire logic       soft_reset_bit,
  input  wire logic       power_down_pin,
  input  wire logic       sleep_pin,
  input  wire logic       managed_mode,
  input  wire logic       sleep_override,
  input  wire logic       mii_detached_state_request,
  input  wire logic       soft_power_down,
  input  wire logic [2:0] indicator_strap_in,
  input  wire logic [5:0] led_select,
  input  wire logic [2:0] led_status_in,
  input  wire logic       test_clk,
  input  wire logic       test_data_in,
  input  wire logic       test_chain_out,
  output logic [2:0]      indicator_strap_out,
  output logic [2:0]      indicator_strap_oe_n,
  output logic [2:0]      config_straps,
  output pin_mode_pkg::mii_pins_t mii_pins,
  output pin_mode_pkg::pin_mode_t pin_mode,
  output logic            internal_reset,
  output logic            test_data_captured,
  output logic            test_data_out
);

  typedef struct packed {
    logic [pin_mode_pkg::STRETCH_W-1:0] stretch;
    logic                               in_reset;
    pin_mode_pkg::pin_mode_t            mode;
    pin_mode_pkg::mii_pins_t            pins;
    logic                               tck_prev;
    logic                               tdi_cap;
    logic                               tdo;
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;
  logic       reset_asserted;
  logic       sleep_allowed;
  logic       tck_rise;
  logic       tck_fall;
  pin_mode_pkg::led_status_t led_status;
  logic [2:0] strap_bits;
  logic [2:0] led_level;
  logic [2:0] led_oe_n;

  assign reset_asserted = !phy_reset_n || soft_reset_bit;
  assign sleep_allowed = managed_mode ? sleep_override : sleep_pin;
  assign tck_rise = test_clk && !state.tck_prev;
  assign tck_fall = !test_clk && state.tck_prev;
  assign led_status.status = led_status_in;

  always_comb begin
    next_state = state;
    next_state.tck_prev = test_clk;
    if (tck_rise) begin
      next_state.tdi_cap = test_data_in;
    end
    if (tck_fall) begin
      next_state.tdo = test_chain_out;
    end
    // Counter holds internal reset for the full stretch after release
    if (reset_asserted) begin
      next_state.in_reset = 1'b1;
      next_state.stretch = pin_mode_pkg::STRETCH_W'(pin_mode_pkg::RESET_STRETCH_CYCLES);
    end else if (state.stretch != pin_mode_pkg::STRETCH_ZERO) begin
      next_state.stretch = state.stretch - pin_mode_pkg::STRETCH_ONE;
      next_state.in_reset = 1'b1;
    end else begin
      next_state.in_reset = 1'b0;
    end
    if (power_down_pin) begin
      next_state.mode = pin_mode_pkg::hardware_power_down_state;
    end else if (next_state.in_reset) begin
      next_state.mode = pin_mode_pkg::hardware_reset_state;
    end else if (mii_detached_state_request) begin
      next_state.mode = pin_mode_pkg::mii_detached_state;
    end else if (sleep_allowed) begin
      next_state.mode = pin_mode_pkg::sleep_state;
    end else if (soft_power_down) begin
      next_state.mode = pin_mode_pkg::software_power_down_state;
    end else begin
      next_state.mode = pin_mode_pkg::pin_normal;
    end
    // Pin controls follow the chosen mode in the same registered cycle
    next_state.pins.tx_inputs = '{level: 1'b0, oe_n: 1'b1, weak_pull_down: 1'b1};
    case (next_state.mode)
      pin_mode_pkg::hardware_reset_state: begin
        next_state.pins.rx_data = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.mii_clocks = '{level: 1'b1, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.clocks_run = 1'b0;
      end
      pin_mode_pkg::software_power_down_state: begin
        next_state.pins.rx_data = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.mii_clocks = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.clocks_run = 1'b1;
      end
      pin_mode_pkg::hardware_power_down_state: begin
        next_state.pins.rx_data = '{level: 1'b0, oe_n: 1'b1, weak_pull_down: 1'b0};
        next_state.pins.mii_clocks = '{level: 1'b0, oe_n: 1'b1, weak_pull_down: 1'b0};
        next_state.pins.tx_inputs = '{level: 1'b0, oe_n: 1'b1, weak_pull_down: 1'b0};
        next_state.pins.clocks_run = 1'b0;
      end
      pin_mode_pkg::mii_detached_state: begin
        next_state.pins.rx_data = '{level: 1'b0, oe_n: 1'b1, weak_pull_down: 1'b1};
        next_state.pins.mii_clocks = '{level: 1'b0, oe_n: 1'b1, weak_pull_down: 1'b1};
        next_state.pins.clocks_run = 1'b0;
      end
      pin_mode_pkg::sleep_state: begin
        next_state.pins.rx_data = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.mii_clocks = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.clocks_run = 1'b0;
      end
      default: begin
        // Normal: data path owns levels, pins driven, clocks running
        next_state.pins.rx_data = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.mii_clocks = '{level: 1'b0, oe_n: 1'b0, weak_pull_down: 1'b0};
        next_state.pins.clocks_run = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state.stretch <= pin_mode_pkg::STRETCH_W'(pin_mode_pkg::RESET_STRETCH_CYCLES);
      state.in_reset <= 1'b1;
      state.mode <= pin_mode_pkg::hardware_reset_state;
      state.pins <= '{rx_data: '{1'b0, 1'b0, 1'b0}, mii_clocks: '{1'b1, 1'b0, 1'b0},
                      tx_inputs: '{1'b0, 1'b1, 1'b1}, clocks_run: 1'b0};
      state.tck_prev <= 1'b0;
      state.tdi_cap <= 1'b0;
      state.tdo <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_led
      led_pin u_led (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .in_reset (state.in_reset),
        .pin_in   (indicator_strap_in[i]),
        .select   (led_select[2*i+1:2*i]),
        .status   (led_status.status),
        .strap    (strap_bits[i]),
        .led_out  (led_level[i]),
        .led_oe_n (led_oe_n[i])
      );
    end
  endgenerate

  assign indicator_strap_out = led_level;
  assign indicator_strap_oe_n = led_oe_n;
  assign config_straps = strap_bits;
  assign mii_pins = state.pins;
  assign pin_mode = state.mode;
  assign internal_reset = state.in_reset;
  assign test_data_captured = state.tdi_cap;
  assign test_data_out = state.tdo;

endmodule

// file: pin_mode_assertions.sv
// Checker for the MII pin modes, reset request and indicator release
`timescale 1ns/10ps
module pin_mode_assertions (
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  input wire logic                    phy_reset_n,
  input wire logic                    soft_reset_bit,
  input wire logic                    power_down_pin,
  input wire logic [2:0]              indicator_strap_oe_n,
  input wire pin_mode_pkg::mii_pins_t mii_pins,
  input wire pin_mode_pkg::pin_mode_t pin_mode,
  input wire logic                    internal_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire ro = mii_pins.rx_data.oe_n, rl = mii_pins.rx_data.level, rp = mii_pins.rx_data.weak_pull_down;
  wire co = mii_pins.mii_clocks.oe_n, cl = mii_pins.mii_clocks.level, cp = mii_pins.mii_clocks.weak_pull_down;
  wire tp = mii_pins.tx_inputs.weak_pull_down;
  wire hr = pin_mode == pin_mode_pkg::hardware_reset_state;
  wire sw = pin_mode == pin_mode_pkg::software_power_down_state;
  wire hp = pin_mode == pin_mode_pkg::hardware_power_down_state;
  wire dt = pin_mode == pin_mode_pkg::mii_detached_state;
  wire sl = pin_mode == pin_mode_pkg::sleep_state;
  a_power_down_wins: assert property (power_down_pin |=> hp) else $error("power-down ignored");
  a_float_power_down: assert property (hp |-> ro && co && !rp && !cp && !tp) else $error("power-down pins");
  a_detached_release: assert property (dt |-> ro && co && rp && cp && tp) else $error("mii_detached_state pins");
  a_reset_drive: assert property (hr |-> !ro && !rl && !co && cl && tp) else $error("reset pins");
  a_sleep_low: assert property (sl |-> !ro && !rl && !co && !cl && tp) else $error("sleep pins");
  a_swpd_running: assert property (sw |-> !ro && !rl && mii_pins.clocks_run && tp) else $error("swpd pins");
  a_reset_or: assert property (!phy_reset_n || soft_reset_bit |-> ##[1:2] internal_reset) else $error("reset lost");
  a_strap_release: assert property (internal_reset && $past(internal_reset) |-> &indicator_strap_oe_n)
    else $error("indicator driven in reset");
endmodule
bind phy_pin_mode_control pin_mode_assertions i_chk (
  .clk_sys              (clk_sys),
  .reset_n              (reset_n),
  .phy_reset_n          (phy_reset_n),
  .soft_reset_bit       (soft_reset_bit),
  .power_down_pin       (power_down_pin),
  .indicator_strap_oe_n (indicator_strap_oe_n),
  .mii_pins             (mii_pins),
  .pin_mode             (pin_mode),
  .internal_reset       (internal_reset)
);

// file: pin_mode_pkg.sv
// Shared types and constants for the MII pin mode controller
package pin_mode_pkg;

  localparam int RESET_STRETCH_US = 258;
  localparam int CLK_MHZ = 100;
  localparam int RESET_STRETCH_CYCLES = RESET_STRETCH_US * CLK_MHZ;
  localparam int STRETCH_W = 15;
  localparam logic [STRETCH_W-1:0] STRETCH_ZERO = 15'h0000;
  localparam logic [STRETCH_W-1:0] STRETCH_ONE = 15'h0001;
  localparam logic [1:0] LED_SEL_RESET = 2'h0;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  typedef enum logic [2:0] {
    pin_normal                = 3'b000,
    hardware_reset_state      = 3'b001,
    software_power_down_state = 3'b010,
    hardware_power_down_state = 3'b011,
    mii_detached_state        = 3'b100,
    sleep_state               = 3'b101
  } pin_mode_t;

  // Per group of pins: drive value, output enable (low = driving), weak pull-down
  typedef struct packed {
    logic level;
    logic oe_n;
    logic weak_pull_down;
  } pin_ctl_t;

  typedef struct packed {
    pin_ctl_t rx_data;
    pin_ctl_t mii_clocks;
    pin_ctl_t tx_inputs;
    logic     clocks_run;
  } mii_pins_t;

  typedef struct packed {
    logic [2:0] status;
  } led_status_t;

endpackage

// file: tb.sv
// Random and corner-case bench for the pin mode controller
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'h0, reset_n = 1'h0, phy_reset_n = 1'h0, soft_reset_bit = 1'h0, power_down_pin = 1'h0;
  logic sleep_pin = 1'h0, managed_mode = 1'h0, sleep_override = 1'h0, mii_detached_state_request = 1'h0;
  logic soft_power_down = 1'h0, test_clk = 1'h0, test_data_in = 1'h0, test_chain_out = 1'h0;
  logic [2:0] indicator_strap_in = 3'h0, led_status_in = 3'h0, indicator_strap_out, indicator_strap_oe_n;
  logic [2:0] config_straps, s, e;
  logic [5:0] led_select = 6'h3F;
  logic [1:0] b;
  logic       internal_reset, test_data_captured, test_data_out, rx_wire;
  pin_mode_pkg::mii_pins_t mii_pins;
  pin_mode_pkg::pin_mode_t pin_mode, m;
  int errors = 0, checks = 0, hi = 0;
  phy_pin_mode_control i_dut (
    .clk_sys              (clk_sys),
    .reset_n              (reset_n),
    .phy_reset_n          (phy_reset_n),
    .soft_reset_bit       (soft_reset_bit),
    .power_down_pin       (power_down_pin),
    .sleep_pin            (sleep_pin),
    .managed_mode         (managed_mode),
    .sleep_override       (sleep_override),
    .mii_detached_state_request      (mii_detached_state_request),
    .soft_power_down      (soft_power_down),
    .indicator_strap_in   (indicator_strap_in),
    .led_select           (led_select),
    .led_status_in        (led_status_in),
    .test_clk             (test_clk),
    .test_data_in         (test_data_in),
    .test_chain_out       (test_chain_out),
    .indicator_strap_out  (indicator_strap_out),
    .indicator_strap_oe_n (indicator_strap_oe_n),
    .config_straps        (config_straps),
    .mii_pins             (mii_pins),
    .pin_mode             (pin_mode),
    .internal_reset       (internal_reset),
    .test_data_captured   (test_data_captured),
    .test_data_out        (test_data_out)
  );
  mac_model i_mac (
    .clk_sys  (clk_sys),
    .mii_pins (mii_pins),
    .rx_wire  (rx_wire)
  );
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (reset_n && internal_reset) hi <= hi + 1;
  function automatic pin_mode_pkg::pin_mode_t em(input logic pd, rs, iso, slp, swpd);
    if (pd) return pin_mode_pkg::hardware_power_down_state;
    if (rs) return pin_mode_pkg::hardware_reset_state;
    if (iso) return pin_mode_pkg::mii_detached_state;
    if (slp) return pin_mode_pkg::sleep_state;
    if (swpd) return pin_mode_pkg::software_power_down_state;
    return pin_mode_pkg::pin_normal;
  endfunction
  // Select code 3 turns an indicator off
  function automatic logic [2:0] led_exp(input logic [5:0] sel, input logic [2:0] st);
    for (int i = 0; i < 3; i++) led_exp[i] = (sel[2*i +: 2] == 2'h3) ? 1'h0 : st[sel[2*i +: 2]];
  endfunction
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task check(input logic [15:0] seen, exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task mode_step(input logic rs);
    logic [7:0] r;
    r = 8'($urandom);
    @(posedge clk_sys);
    power_down_pin <= r[0] & r[6];
    {mii_detached_state_request, sleep_pin, managed_mode, sleep_override, soft_power_down} <= r[5:1];
    tick(3);
    #1;
    m = em(r[0] & r[6], rs, r[5], r[3] ? r[2] : r[4], r[1]);
    check(16'(pin_mode), 16'(m), "pin mode");
    if (m == pin_mode_pkg::sleep_state || m == pin_mode_pkg::mii_detached_state)
      check(16'(rx_wire), 16'h0000, "receive wire");
  endtask
  initial begin
    tick(30000);
    errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hD3DE));
    s = 3'($urandom);
    indicator_strap_in <= s;
    tick(4);
    reset_n <= 1'h1;
    phy_reset_n <= 1'h1;
    // Mode requests while the reset stretch still runs
    repeat (10) mode_step(1'h1);
    @(posedge clk_sys);
    {power_down_pin, mii_detached_state_request, sleep_pin, sleep_override, soft_power_down} <= 5'h00;
    while (internal_reset !== 1'h0) @(posedge clk_sys);
    #1;
    check(16'(hi >= pin_mode_pkg::RESET_STRETCH_CYCLES), 16'h0001, "stretch short");
    check(16'(hi < pin_mode_pkg::RESET_STRETCH_CYCLES + 4), 16'h0001, "stretch long");
    @(posedge clk_sys);
    indicator_strap_in <= ~s;
    tick(3);
    #1;
    check(16'(config_straps), 16'(s), "straps");
    repeat (8) begin
      @(posedge clk_sys);
      led_status_in <= 3'($urandom);
      led_select <= 6'($urandom);
      tick(3);
      #1;
      e = led_exp(led_select, led_status_in);
      check(16'(indicator_strap_out), 16'(e), "indicator");
      check(16'(indicator_strap_oe_n), 16'h0000, "indicator drive");
    end
    // Data moves while the test clock holds, so only edges may count
    repeat (4) begin
      b = 2'($urandom);
      @(posedge clk_sys);
      test_data_in <= b[0];
      tick(2);
      test_clk <= 1'h1;
      tick(3);
      test_data_in <= ~b[0];
      test_chain_out <= b[1];
      tick(3);
      test_clk <= 1'h0;
      tick(3);
      test_chain_out <= ~b[1];
      tick(3);
      #1;
      check(16'(test_data_captured), 16'(b[0]), "capture");
      check(16'(test_data_out), 16'(b[1]), "shift out");
    end
    repeat (60) mode_step(1'h0);
    @(posedge clk_sys);
    soft_reset_bit <= 1'h1;
    @(posedge clk_sys);
    soft_reset_bit <= 1'h0;
    tick(3);
    #1;
    check(16'(internal_reset), 16'h0001, "soft reset");
    check(16'(pin_mode), 16'(em(power_down_pin, 1'h1, 1'h0, 1'h0, 1'h0)), "soft reset mode");
    tally_and_finish;
  end
endmodule
